// ---- core/dcpm_ctrl.sv ----
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1 - Fast clock divided by two power 0..7
// RULE2 - Slow clock drives 14-bit tick divider
// RULE3 - Mode bit enables tick divider; slow mode and standby run it even with the bit clear
// RULE4 - Writing zero clears tick count; reads one
// RULE5 - Normal: CPU on divided fast clock
// RULE6 - Slow: CPU on slow clock, fast off
// RULE7 - Standby: CPU and fast stopped, slow runs
// RULE8 - Standby wakes on four event kinds
// RULE9 - Halt stops all; key or external wake
// RULE10 - Mode register and sleep register drive modes
// RULE11 - Oscillator sources are one-time options
// RULE12 - Bit 7 selects fast or slow CPU
// RULE13 - Only 0x5A written to sleep register sleeps
// RULE14 - Sleep enters standby if ticks enabled, else halt
// RULE15 - Wake resumes per bit 7 after settling
// RULE16 - All clock switching glitch-free
module dcpm_ctrl
    import dcpm_pkg::*;
#(
    parameter int FAST_SETTLE = FAST_SETTLE_CYC,
    parameter int SLOW_SETTLE = XTAL_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                      CLOCK_I,
    input  wire logic                      ARST_N_I,
    // One-time option straps
    input  wire logic [1:0]                FAST_SRC_OPT_I,
    input  wire logic                      SLOW_XTAL_OPT_I,
    // Oscillator pulses (asynchronous levels)
    input  wire logic                      FAST_OSC_I,
    input  wire logic                      SLOW_OSC_I,
    // Register port
    input  wire logic [7:0]                ADDR_I,
    input  wire logic [7:0]                WDATA_I,
    input  wire logic                      WR_I,
    input  wire logic                      RD_I,
    output logic      [7:0]                RDATA_O,
    // Wake-up events (asynchronous)
    input  wire logic                      KEY_CHANGE_I,
    input  wire logic                      SLOW_TIMER_IRQ_I,
    input  wire logic                      TICK_IRQ_I,
    input  wire logic                      EXT_IRQ_I,
    // Derived clock enables and status
    output logic                           CPU_CLK_EN_O,
    output logic                           FAST_OSC_EN_O,
    output logic                           SLOW_OSC_EN_O,
    output logic                           FAST_DIV_EN_O,
    output logic      [TICK_W-1:0]         TICK_DIV_O,
    output logic      [2:0]                MODE_O,
    output logic      [1:0]                FAST_SRC_O,
    output logic                           SLOW_XTAL_O
);
    import dcpm_pkg::*;

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic [5:0] raw_in;
    assign raw_in = {FAST_OSC_I, SLOW_OSC_I, KEY_CHANGE_I, SLOW_TIMER_IRQ_I, TICK_IRQ_I, EXT_IRQ_I};
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    logic fast_lvl;
    logic slow_lvl;
    logic fast_prev;
    logic slow_prev;
    logic fast_edge;
    logic slow_edge;
    assign fast_lvl  = sync_b[5];
    assign slow_lvl  = sync_b[4];
    assign fast_edge = fast_lvl & ~fast_prev & FAST_OSC_EN_O;
    assign slow_edge = slow_lvl & ~slow_prev & SLOW_OSC_EN_O;

    // ----------------------------------------
    // Option capture after reset release
    // ----------------------------------------
    logic opt_taken;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            opt_taken   <= 1'b0;
            FAST_SRC_O  <= FAST_SRC_4M;
            SLOW_XTAL_O <= 1'b0;
        end else if (!opt_taken) begin
            opt_taken   <= 1'b1;
            FAST_SRC_O  <= FAST_SRC_OPT_I;                   // RULE11
            SLOW_XTAL_O <= SLOW_XTAL_OPT_I;                  // RULE11
        end
    end

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    logic [7:0] operating_mode_register;
    logic       mode_wr;
    logic       sleep_wr;
    logic       sleep_cmd;
    logic       tick_clr;
    logic       tick_en;
    logic       sel_fast;
    logic [2:0] div_sel;
    assign mode_wr   = WR_I & (ADDR_I == MODE_REG_ADDR);
    assign sleep_wr  = WR_I & (ADDR_I == SLEEP_REG_ADDR);
    assign sleep_cmd = sleep_wr & (WDATA_I == SLEEP_KEY);   // RULE13
    assign tick_clr  = mode_wr & ~WDATA_I[TICK_CLR_BIT];    // RULE4
    assign tick_en   = operating_mode_register[TICK_EN_BIT];
    assign sel_fast  = operating_mode_register[CPU_SEL_BIT];
    assign div_sel   = operating_mode_register[DIV_SEL_LSB +: DIV_SEL_W];

    logic [7:0] next_rdata;
    // Clear bit has no storage and always reads high
    assign next_rdata = (RD_I & (ADDR_I == MODE_REG_ADDR)) ?
                        (operating_mode_register | (8'h01 << TICK_CLR_BIT)) : 8'h00; // RULE4

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            operating_mode_register <= MODE_REG_RESET;
            RDATA_O                 <= 8'h00;
        end else begin
            RDATA_O <= next_rdata;
            if (mode_wr) begin
                operating_mode_register <= WDATA_I & ~(8'h01 << TICK_CLR_BIT); // RULE10
            end
        end
    end

    // ----------------------------------------
    // Mode state machine
    // ----------------------------------------
    dcpm_mode_t mode;
    dcpm_mode_t next_mode;
    logic       wake_standby;
    logic       wake_halt;
    logic       settle_done;
    logic       was_halt;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [SETTLE_W-1:0] settle_target;
    localparam logic [SETTLE_W-1:0] FAST_SET_W = SETTLE_W'(FAST_SETTLE);
    localparam logic [SETTLE_W-1:0] SLOW_SET_W = SETTLE_W'(SLOW_SETTLE);
    localparam logic [SETTLE_W-1:0] RC32_SET_W = SETTLE_W'(RC32_SETTLE_CYC);

    assign wake_standby = |sync_b[3:0];                                    // RULE8
    assign wake_halt    = sync_b[3] | sync_b[0];                           // RULE9
    // Counts are in source-oscillator edges; halted slow osc needs its settle too
    assign settle_target = sel_fast ? FAST_SET_W :
                           (was_halt ? (SLOW_XTAL_O ? SLOW_SET_W : RC32_SET_W) : RC32_SET_W);
    assign settle_done   = (settle_cnt >= settle_target);                  // RULE15

    always_comb begin
        next_mode = mode;
        unique case (mode)
            PM_NORMAL: begin
                if (sleep_cmd) begin
                    next_mode = tick_en ? PM_STANDBY : PM_HALT;            // RULE14
                end else if (!sel_fast) begin
                    next_mode = PM_SLOW;                                   // RULE12
                end
            end
            PM_SLOW: begin
                if (sleep_cmd) begin
                    next_mode = tick_en ? PM_STANDBY : PM_HALT;            // RULE14
                end else if (sel_fast) begin
                    next_mode = PM_SETTLE;                                 // RULE12
                end
            end
            PM_STANDBY: begin
                if (wake_standby) begin
                    next_mode = PM_SETTLE;
                end
            end
            PM_HALT: begin
                if (wake_halt) begin
                    next_mode = PM_SETTLE;
                end
            end
            PM_SETTLE: begin
                if (settle_done) begin
                    next_mode = sel_fast ? PM_NORMAL : PM_SLOW;            // RULE15
                end
            end
            default: next_mode = PM_NORMAL;
        endcase
    end

    logic settle_edge;
    assign settle_edge = sel_fast ? fast_edge : slow_edge;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode       <= PM_NORMAL;
            settle_cnt <= '0;
            was_halt   <= 1'b0;
        end else begin
            mode <= next_mode;
            if (mode != PM_SETTLE) begin
                settle_cnt <= '0;
            end else if (settle_edge && !settle_done) begin
                settle_cnt <= settle_cnt + SETTLE_W'(1);
            end
            if (mode == PM_HALT) begin
                was_halt <= 1'b1;
            end else if (mode != PM_SETTLE) begin
                was_halt <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Oscillator enables per mode
    // ----------------------------------------
    logic next_fast_osc;
    logic next_slow_osc;
    logic next_fast_div;
    assign next_fast_osc = (next_mode == PM_NORMAL) |
                           ((next_mode == PM_SETTLE) & sel_fast);          // RULE5 RULE6 RULE7
    assign next_slow_osc = (next_mode != PM_HALT) &
                           ((next_mode != PM_NORMAL) | tick_en | ~sel_fast); // RULE9
    assign next_fast_div = (next_mode == PM_NORMAL);                       // RULE6 RULE7
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            FAST_OSC_EN_O <= 1'b1;
            SLOW_OSC_EN_O <= 1'b1;
            FAST_DIV_EN_O <= 1'b1;
            fast_prev     <= 1'b0;
            slow_prev     <= 1'b0;
            MODE_O        <= 3'h0;
        end else begin
            FAST_OSC_EN_O <= next_fast_osc;
            SLOW_OSC_EN_O <= next_slow_osc;
            FAST_DIV_EN_O <= next_fast_div;
            fast_prev     <= fast_lvl;
            slow_prev     <= slow_lvl;
            MODE_O        <= 3'(next_mode);
        end
    end

    // ----------------------------------------
    // Fast divider: 2^N tick on oscillator edges
    // ----------------------------------------
    logic [6:0] fast_div_cnt;
    logic [6:0] div_mask;
    logic       fast_tick;
    assign div_mask  = 7'((8'h01 << div_sel) - 8'h01);                    // RULE1
    assign fast_tick = fast_edge & FAST_DIV_EN_O & ((fast_div_cnt & div_mask) == div_mask); // RULE1
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fast_div_cnt <= 7'h00;
        end else if (!FAST_DIV_EN_O) begin
            fast_div_cnt <= 7'h00;
        end else if (fast_edge) begin
            // Ratio change applies its new mask to the running count at once, even mid-period
            fast_div_cnt <= fast_tick ? 7'h00 : fast_div_cnt + 7'h01;      // RULE16
        end
    end

    // ----------------------------------------
    // Slow tick divider
    // ----------------------------------------
    logic [TICK_W-1:0] tick_cnt;
    logic              tick_run;
    // Standby and slow keep the divider alive regardless of the enable bit
    assign tick_run = SLOW_OSC_EN_O & (tick_en | (mode == PM_SLOW) | (mode == PM_STANDBY)); // RULE3 RULE6 RULE7
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tick_cnt   <= '0;
            TICK_DIV_O <= '0;
        end else begin
            if (tick_clr) begin
                tick_cnt <= '0;                                            // RULE4
            end else if (tick_run && slow_edge) begin
                tick_cnt <= tick_cnt + TICK_W'(1);                         // RULE2
            end
            TICK_DIV_O <= tick_cnt;                                        // RULE2
        end
    end

    // ----------------------------------------
    // CPU clock selection
    // ----------------------------------------
    logic cpu_run;
    logic cpu_tick;
    assign cpu_run = (mode == PM_NORMAL) | (mode == PM_SLOW);              // RULE5 RULE6
    dcpm_glitchfree_mux u_mux (
        .CLOCK_I     (CLOCK_I),
        .ARST_N_I    (ARST_N_I),
        .sel_slow_i  (mode == PM_SLOW),
        .run_i       (cpu_run),
        .fast_tick_i (fast_tick),
        .slow_tick_i (slow_edge),
        .cpu_tick_o  (cpu_tick),
        .on_fast_o   ()
    );                                                                     // RULE16
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CPU_CLK_EN_O <= 1'b0;
        end else begin
            CPU_CLK_EN_O <= cpu_tick;
        end
    end
endmodule
`default_nettype wire

// ---- core/dcpm_pkg.sv ----
package dcpm_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] MODE_REG_ADDR   = 8'h17;
    localparam logic [7:0] SLEEP_REG_ADDR  = 8'h15;
    localparam logic [7:0] SLEEP_KEY       = 8'h5A;
    localparam logic [7:0] MODE_REG_RESET  = 8'h88;
    localparam int         CPU_SEL_BIT     = 7;
    localparam int         DIV_SEL_LSB     = 4;
    localparam int         DIV_SEL_W       = 3;
    localparam int         TICK_EN_BIT     = 3;
    localparam int         TICK_CLR_BIT    = 2;
    localparam int         TICK_W          = 14;
    // ----------------------------------------
    // Option and timing
    // ----------------------------------------
    localparam logic [1:0] FAST_SRC_4M     = 2'h0;
    localparam logic [1:0] FAST_SRC_2M     = 2'h1;
    localparam logic [1:0] FAST_SRC_500K   = 2'h2;
    localparam int         FAST_SETTLE_CYC = 512;
    localparam int         RC32_SETTLE_CYC = 4;
    localparam int         XTAL_SETTLE_CYC = 1024;
    localparam int         SETTLE_W        = 11;
    typedef enum logic [2:0] {
        PM_NORMAL,
        PM_SLOW,
        PM_STANDBY,
        PM_HALT,
        PM_SETTLE
    } dcpm_mode_t;
endpackage

// ---- core/dcpm_glitchfree_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Glitch-free two-input clock select
// ----------------------------------------
module dcpm_glitchfree_mux (
    // Clock and reset
    input  wire logic CLOCK_I,
    input  wire logic ARST_N_I,
    // Candidate clock enables
    input  wire logic sel_slow_i,
    input  wire logic run_i,
    input  wire logic fast_tick_i,
    input  wire logic slow_tick_i,
    // Gated result
    output logic      cpu_tick_o,
    output logic      on_fast_o
);
    logic fast_own;
    logic slow_own;
    logic next_fast_own;
    logic next_slow_own;
    // Break-before-make: a source is released in the cycle it is deselected or run drops
    assign next_fast_own = run_i & ~sel_slow_i & ~slow_own ? 1'b1 :
                           (fast_tick_i | ~run_i | sel_slow_i) ? 1'b0 : fast_own;
    assign next_slow_own = run_i & sel_slow_i & ~fast_own ? 1'b1 :
                           (slow_tick_i | ~run_i | ~sel_slow_i) ? 1'b0 : slow_own;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fast_own   <= 1'b0;
            slow_own   <= 1'b0;
            cpu_tick_o <= 1'b0;
        end else begin
            fast_own   <= next_fast_own;
            slow_own   <= next_slow_own;
            cpu_tick_o <= (fast_own & fast_tick_i) | (slow_own & slow_tick_i);
        end
    end
    assign on_fast_o = fast_own;
endmodule
`default_nettype wire

// ---- dv/dcpm_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port-level checks of the mode controller
// ----------------------------------------
module dcpm_monitor
    import dcpm_pkg::*;
(
    // Clock and reset
    input wire logic                         CLOCK_I,
    input wire logic                         ARST_N_I,
    // Straps and register port
    input wire logic [1:0]                   FAST_SRC_OPT_I,
    input wire logic [7:0]                   ADDR_I,
    input wire logic [7:0]                   WDATA_I,
    input wire logic                         WR_I,
    input wire logic                         RD_I,
    input wire logic [7:0]                   RDATA_O,
    // Clock enables and status
    input wire logic                         CPU_CLK_EN_O,
    input wire logic                         FAST_OSC_EN_O,
    input wire logic                         SLOW_OSC_EN_O,
    input wire logic                         FAST_DIV_EN_O,
    input wire logic [dcpm_pkg::TICK_W-1:0]  TICK_DIV_O,
    input wire logic [2:0]                   MODE_O,
    input wire logic [1:0]                   FAST_SRC_O
);
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (!ARST_N_I);

    a_rdata_idle: assert property (RDATA_O != 8'h00 |-> $past(RD_I))
        else $error("read data without a read");
    a_clr_reads_one: assert property ($past(RD_I) && $past(ADDR_I) == MODE_REG_ADDR |-> RDATA_O[TICK_CLR_BIT])
        else $error("clear bit read back low");
    // The CPU enable lags the mode by a cycle or two, so only settled modes count
    a_slow_fast_off: assert property (
        (MODE_O == PM_SLOW) [*4] |-> !FAST_OSC_EN_O && !FAST_DIV_EN_O && SLOW_OSC_EN_O)
        else $error("fast clock running in slow mode");
    a_standby_clocks: assert property (
        (MODE_O == PM_STANDBY) [*4] |-> !CPU_CLK_EN_O && !FAST_OSC_EN_O && SLOW_OSC_EN_O)
        else $error("wrong clocks in standby");
    a_halt_all_off: assert property (
        (MODE_O == PM_HALT) [*4] |->
            !CPU_CLK_EN_O && !FAST_OSC_EN_O && !SLOW_OSC_EN_O && $stable(TICK_DIV_O))
        else $error("clock alive in halt");
    a_key_sleeps: assert property (
        WR_I && ADDR_I == SLEEP_REG_ADDR && WDATA_I == SLEEP_KEY && (MODE_O == PM_NORMAL || MODE_O == PM_SLOW)
            |-> ##[1:4] (MODE_O == PM_STANDBY || MODE_O == PM_HALT))
        else $error("sleep key not obeyed");
    a_nonkey_ignored: assert property (
        WR_I && ADDR_I == SLEEP_REG_ADDR && WDATA_I != SLEEP_KEY && MODE_O == PM_NORMAL && !$past(WR_I)
            |-> ##2 MODE_O == PM_NORMAL)
        else $error("sleep without key");
    a_cpu_single: assert property (CPU_CLK_EN_O |=> !CPU_CLK_EN_O)
        else $error("processor tick wider than one cycle");
    a_options_held: assert property (!$stable(FAST_SRC_OPT_I) |=> $stable(FAST_SRC_O))
        else $error("option followed strap at run time");
endmodule

bind dcpm_ctrl dcpm_monitor u_monitor (
    .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .FAST_SRC_OPT_I(FAST_SRC_OPT_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CPU_CLK_EN_O(CPU_CLK_EN_O), .FAST_OSC_EN_O(FAST_OSC_EN_O), .SLOW_OSC_EN_O(SLOW_OSC_EN_O),
    .FAST_DIV_EN_O(FAST_DIV_EN_O), .TICK_DIV_O(TICK_DIV_O), .MODE_O(MODE_O), .FAST_SRC_O(FAST_SRC_O)
);
`default_nettype wire

// ---- dv/dcpm_osc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Oscillators, frozen low while disabled
// ----------------------------------------
module dcpm_osc_model (
    // Enables from the controller
    input  wire logic fast_en_i,
    input  wire logic slow_en_i,
    // Waveforms
    output logic      fast_osc_o,
    output logic      slow_osc_o
);
    initial begin
        fast_osc_o = 1'b0;
        #3.3;
        forever #20 fast_osc_o = fast_en_i ? ~fast_osc_o : 1'b0;
    end
    initial begin
        slow_osc_o = 1'b0;
        // Offset keeps toggles off the clock edges, no sampling race
        #1.7;
        forever #100 slow_osc_o = slow_en_i ? ~slow_osc_o : 1'b0;
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dcpm_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic              clk, arst_n, wr, rd, sxtal, key, tmr, tick, ext, fosc, sosc, rd_d;
    logic              cpu_en, fosc_en, sosc_en, fdiv_en, sxtal_o;
    logic [1:0]        fast_opt, fsrc;
    logic [7:0]        addr, wdata, rdata, d, r;
    logic [2:0]        mode;
    logic [TICK_W-1:0] tick_div, t0;
    logic [7:0]        exp_q[$];
    int                n_errors, n_compared, seed, c, k;

    dcpm_ctrl #(.FAST_SETTLE(4), .SLOW_SETTLE(4)) uut (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .FAST_SRC_OPT_I(fast_opt), .SLOW_XTAL_OPT_I(sxtal),
        .FAST_OSC_I(fosc), .SLOW_OSC_I(sosc), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .KEY_CHANGE_I(key), .SLOW_TIMER_IRQ_I(tmr),
        .TICK_IRQ_I(tick), .EXT_IRQ_I(ext), .CPU_CLK_EN_O(cpu_en), .FAST_OSC_EN_O(fosc_en),
        .SLOW_OSC_EN_O(sosc_en), .FAST_DIV_EN_O(fdiv_en), .TICK_DIV_O(tick_div),
        .MODE_O(mode), .FAST_SRC_O(fsrc), .SLOW_XTAL_O(sxtal_o)
    );
    dcpm_osc_model u_osc (.fast_en_i(fosc_en), .slow_en_i(sosc_en), .fast_osc_o(fosc), .slow_osc_o(sosc));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Oscillator phase against the window makes counts fuzzy by a tick or two
    task automatic near(input string name, input logic [15:0] got, input int exp);
        check(name, 16'(got >= exp - 2 && got <= exp + 2), 16'h0001);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic wait_mode(input logic [2:0] m);
        int i;
        i = 0;
        while (mode !== m && i < 2000) begin
            @(posedge clk);
            i++;
        end
        check("mode", mode, 16'(m));
    endtask
    task automatic count_cpu(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (cpu_en === 1'b1) c++;
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) check("read data", rdata, exp_q.pop_front());
        rd_d <= rd;
    end
    initial begin
        #600000;
        n_errors++;
        end_sim();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {arst_n, wr, rd, key, tmr, tick, ext, addr, wdata} = '0;
        fast_opt = FAST_SRC_2M;
        sxtal = 1'b1;
        seed = 95657;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        // Straps land on the first edge after release, seen one edge later
        @(posedge clk);
        @(posedge clk);
        check("reset mode", mode, 16'(PM_NORMAL));
        check("slow option", sxtal_o, 1'b1);
        rdx(MODE_REG_ADDR, MODE_REG_RESET | 8'h04);
        rdx(SLEEP_REG_ADDR, 8'h00);
        rdx(8'h16, 8'h00);
        fast_opt <= FAST_SRC_500K;
        for (k = 0; k < 8; k++) begin
            wrr(MODE_REG_ADDR, 8'h8C | 8'(k << 4));
            repeat (20) @(posedge clk);
            count_cpu(2560);
            near("cpu ticks", 16'(c), 512 >> k);
        end
        check("fast option", fsrc, FAST_SRC_2M);
        for (k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            if (d == SLEEP_KEY) d = 8'h00;
            wrr(SLEEP_REG_ADDR, d);
            r = 8'($random(seed)) & 8'h03;
            wrr(MODE_REG_ADDR, 8'h8C | r);
            rdx(MODE_REG_ADDR, 8'h8C | r);
        end
        check("mode after bad key", mode, 16'(PM_NORMAL));
        wrr(MODE_REG_ADDR, 8'h84);
        repeat (10) @(posedge clk);
        t0 = tick_div;
        repeat (200) @(posedge clk);
        check("tick held", tick_div, t0);
        wrr(MODE_REG_ADDR, 8'h88);
        wrr(MODE_REG_ADDR, 8'h8C);
        repeat (2500) @(posedge clk);
        near("tick count", tick_div, 100);
        wrr(MODE_REG_ADDR, 8'h0C);
        wait_mode(PM_SLOW);
        repeat (20) @(posedge clk);
        check("fast osc off", fosc_en, 1'b0);
        check("fast div off", fdiv_en, 1'b0);
        count_cpu(2500);
        near("slow cpu ticks", 16'(c), 100);
        for (k = 0; k < 4; k++) begin
            wrr(SLEEP_REG_ADDR, SLEEP_KEY);
            wait_mode(PM_STANDBY);
            repeat (10) @(posedge clk);
            check("standby cpu", cpu_en, 1'b0);
            check("standby slow osc", sosc_en, 1'b1);
            {key, tmr, tick, ext} <= 4'b1000 >> k;
            wait_mode(PM_SLOW);
            {key, tmr, tick, ext} <= 4'h0;
            repeat (10) @(posedge clk);
        end
        wrr(MODE_REG_ADDR, 8'h84);
        wait_mode(PM_NORMAL);
        for (k = 0; k < 2; k++) begin
            wrr(SLEEP_REG_ADDR, SLEEP_KEY);
            wait_mode(PM_HALT);
            {tmr, tick} <= 2'b11;
            repeat (300) @(posedge clk);
            check("halt holds", mode, 16'(PM_HALT));
            check("halt slow osc", sosc_en, 1'b0);
            {key, ext} <= (k == 0) ? 2'b10 : 2'b01;
            wait_mode(PM_NORMAL);
            {key, tmr, tick, ext} <= 4'h0;
            repeat (10) @(posedge clk);
        end
        end_sim();
    end
endmodule
`default_nettype wire
